// *** verilog/cihs_pkg.sv ***
// Shared constants, register map and state type of the caller-ID host sequencer.
package cihs_pkg;

  // ----------------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------------
  localparam int CLK_HZ         = 100_000_000;
  localparam int MS_PER_S       = 1000;
  localparam int MS_CYCLES      = CLK_HZ / MS_PER_S;
  localparam int DIV_W          = 17;
  localparam int MS_W           = 16;
  // Line load applied this long after the alert tone ends (window 15..25 ms).
  localparam logic [15:0] LOAD_ALERT_MS = 16'h0014;
  // Line load applied this long after the ring burst ends (window 250..400 ms).
  localparam logic [15:0] LOAD_BURST_MS = 16'h012c;
  // Line load removed this long after the carrier ends (window 50..150 ms).
  localparam logic [15:0] LOAD_OFF_MS   = 16'h0064;

  // ----------------------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_CD_TO    = 8'h10;
  localparam logic [7:0] ADDR_FSK_TO   = 8'h14;

  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_WAKE_LATE  = 2;
  localparam int CTRL_SEL_HIGH   = 3;
  localparam int CTRL_ENABLE     = 4;
  localparam int CTRL_OFFHOOK_GO = 8;
  localparam int CTRL_ACK_DONE   = 9;

  localparam logic [1:0] MODE_RING  = 2'h0;
  localparam logic [1:0] MODE_ALERT = 2'h1;
  localparam logic [1:0] MODE_BURST = 2'h2;

  localparam int EV_W       = 5;
  localparam int EV_RING    = 0;
  localparam int EV_CARRIER = 1;
  localparam int EV_DONE    = 2;
  localparam int EV_TIMEOUT = 3;
  localparam int EV_ALERT   = 4;

  localparam logic [15:0] CD_TO_RESET  = 16'h0bb8;
  localparam logic [15:0] FSK_TO_RESET = 16'h01f4;

  // ----------------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_RING_END, S_ALERT, S_LOAD_DLY, S_CD_WAIT, S_FSK_RX, S_POST_FSK,
    S_OH_ALERT, S_OH_FSK_WAIT, S_OH_FSK
  } cihs_state_t;

endpackage : cihs_pkg

// *** verilog/cihs_tmr_if.sv ***
// Request and expiry signals between the sequencer and its millisecond timer.
interface cihs_tmr_if;
  logic        start;
  logic [15:0] ms;
  logic        expired;
  modport ctl (output start, output ms, input expired);
  modport tmr (input start, input ms, output expired);
endinterface : cihs_tmr_if

// *** verilog/cihs_mstimer.sv ***
// Millisecond one-shot timer driven by a divided one-cycle tick.
module cihs_mstimer #(
  parameter logic [16:0] DIV = 17'h186a0
) (
  input wire logic core_clk,
  input wire logic nrst,
  cihs_tmr_if.tmr  t
);

  typedef struct packed {
    logic [16:0] div;
    logic [15:0] left;
    logic        run;
    logic        expired;
  } cihs_tmr_st_t;

  cihs_tmr_st_t s;
  cihs_tmr_st_t next_s;

  assign t.expired = s.expired;

  // ----------------------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------------------
  // A new start restarts the count and drops an old expiry due in the cycle the start arrives, so it never reaches the later wait.
  always_comb
  begin
    next_s         = s;
    next_s.expired = 1'b0;
    if (t.start)
    begin
      next_s.div     = '0;
      next_s.left    = t.ms;
      next_s.run     = (t.ms != '0);
      next_s.expired = (t.ms == '0);
    end
    else if (s.run)
    begin
      if (s.div == DIV - 17'h00001)
      begin
        next_s.div = '0;
        if (s.left <= 16'h0001)
        begin
          next_s.run     = 1'b0;
          next_s.expired = 1'b1;
        end
        else
        begin
          next_s.left = s.left - 16'h0001;
        end
      end
      else
      begin
        next_s.div = s.div + 17'h00001;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

endmodule : cihs_mstimer

// *** verilog/cihs_sequencer.sv ***
// Caller-ID host sequencer: wakes the receiver, steers its detector select and line load.
// Behaviour
// - select low while an alert tone is expected.
// - select may stay high while on-hook.
// - off-hook: select high once acknowledge is sent.
// - off-hook: select low after carrier ends.
// - on-hook: sleep receiver after carrier ends.
// - no carrier after wake: time out, sleep.
// - off-hook failure: select low, unmute, keypad on.
// - idle-state: select low while FSK unexpected.
// - optionally wake only after ring indication ends.
// - idle-state: apply loads 20 ms after alert.
// - remove loads 50-150 ms after FSK; sleep.
// - ring-burst: apply loads 250-400 ms after burst.
// - skip waking at ring after completed data.
module cihs_sequencer #(
  parameter int MS_DIV = cihs_pkg::MS_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        ring_on_indication,
  input  wire logic        alert_detect,
  input  wire logic        carrier_detect_n,
  output logic             rx_wake,
  output logic             detector_select,
  output logic             line_load,
  output logic             handset_mute,
  output logic             keypad_enable,
  output logic             irq
);

  typedef struct packed {
    cihs_pkg::cihs_state_t st;
    logic [1:0]            mode;
    logic                  wake_late;
    logic                  sel_high;
    logic                  enable;
    logic [4:0]            irq_stat;
    logic [4:0]            irq_mask;
    logic [15:0]           cd_to;
    logic [15:0]           fsk_to;
    logic                  skip_ring;
    logic                  ring_q;
    logic                  alert_q;
    logic                  wake;
    logic                  sel;
    logic                  load;
    logic                  mute;
    logic                  keypad;
    logic                  irq;
    logic                  waitreq;
    logic [31:0]           rdata;
    logic                  tmr_start;
    logic [15:0]           tmr_ms;
  } cihs_seq_st_t;

  cihs_seq_st_t s;
  cihs_seq_st_t next_s;
  cihs_tmr_if   tmr ();
  logic         wr_acc;
  logic         rd_take;
  logic         ring_rise;
  logic         ring_fall;
  logic         alert_fall;
  logic         idle_sel;
  logic [4:0]   ev;

  cihs_mstimer #(
    .DIV (17'(MS_DIV))
  ) u_timer (
    .core_clk (core_clk),
    .nrst     (nrst),
    .t        (tmr)
  );

  assign tmr.start       = s.tmr_start;
  assign tmr.ms          = s.tmr_ms;
  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign rx_wake         = s.wake;
  assign detector_select = s.sel;
  assign line_load       = s.load;
  assign handset_mute    = s.mute;
  assign keypad_enable   = s.keypad;
  assign irq             = s.irq;

  // ----------------------------------------------------------------------------
  // Bus handshake and edge detection
  // ----------------------------------------------------------------------------
  // One wait state per access: the reply is prepared while waitrequest is high.
  assign wr_acc     = avs_write && !s.waitreq;
  assign rd_take    = avs_read && s.waitreq;
  assign ring_rise  = ring_on_indication && !s.ring_q;
  assign ring_fall  = !ring_on_indication && s.ring_q;
  assign alert_fall = !alert_detect && s.alert_q;
  // Idle-state mode keeps the demodulator off until after the alert tone.
  assign idle_sel   = s.sel_high && (s.mode != cihs_pkg::MODE_ALERT);

  // ----------------------------------------------------------------------------
  // Sequencer and registers
  // ----------------------------------------------------------------------------
  always_comb
  begin
    next_s           = s;
    next_s.tmr_start = 1'b0;
    next_s.ring_q    = ring_on_indication;
    next_s.alert_q   = alert_detect;
    next_s.waitreq   = !((avs_read || avs_write) && s.waitreq);
    ev               = '0;
    case (s.st)
      cihs_pkg::S_IDLE:
      begin
        next_s.sel = idle_sel;
        if (wr_acc && avs_address == cihs_pkg::ADDR_CTRL && avs_writedata[cihs_pkg::CTRL_OFFHOOK_GO])
        begin
          next_s.wake   = 1'b1;
          next_s.sel    = 1'b0;
          next_s.mute   = 1'b1;
          next_s.keypad = 1'b0;
          next_s.st     = cihs_pkg::S_OH_ALERT;
        end
        else if (s.enable && ring_rise)
        begin
          ev[cihs_pkg::EV_RING] = 1'b1;
          if (s.skip_ring)
          begin
            next_s.skip_ring = 1'b0;
          end
          else if (s.mode == cihs_pkg::MODE_ALERT)
          begin
            next_s.wake      = 1'b1;
            next_s.sel       = 1'b0;
            next_s.tmr_start = 1'b1;
            next_s.tmr_ms    = s.cd_to;
            next_s.st        = cihs_pkg::S_ALERT;
          end
          else if (s.mode == cihs_pkg::MODE_BURST || s.wake_late)
          begin
            next_s.st = cihs_pkg::S_RING_END;
          end
          else
          begin
            next_s.wake      = 1'b1;
            next_s.sel       = 1'b1;
            next_s.tmr_start = 1'b1;
            next_s.tmr_ms    = s.cd_to;
            next_s.st        = cihs_pkg::S_CD_WAIT;
          end
        end
      end
      cihs_pkg::S_RING_END:
      begin
        if (ring_fall)
        begin
          next_s.wake      = 1'b1;
          next_s.sel       = 1'b1;
          next_s.tmr_start = 1'b1;
          if (s.mode == cihs_pkg::MODE_BURST)
          begin
            next_s.tmr_ms = cihs_pkg::LOAD_BURST_MS;
            next_s.st     = cihs_pkg::S_LOAD_DLY;
          end
          else
          begin
            next_s.tmr_ms = s.cd_to;
            next_s.st     = cihs_pkg::S_CD_WAIT;
          end
        end
      end
      cihs_pkg::S_ALERT:
      begin
        if (alert_fall)
        begin
          ev[cihs_pkg::EV_ALERT] = 1'b1;
          next_s.tmr_start       = 1'b1;
          next_s.tmr_ms          = cihs_pkg::LOAD_ALERT_MS;
          next_s.st              = cihs_pkg::S_LOAD_DLY;
        end
        else if (tmr.expired)
        begin
          ev[cihs_pkg::EV_TIMEOUT] = 1'b1;
          next_s.wake              = 1'b0;
          next_s.st                = cihs_pkg::S_IDLE;
        end
      end
      cihs_pkg::S_LOAD_DLY:
      begin
        if (tmr.expired)
        begin
          next_s.load      = 1'b1;
          next_s.sel       = 1'b1;
          next_s.tmr_start = 1'b1;
          next_s.tmr_ms    = s.cd_to;
          next_s.st        = cihs_pkg::S_CD_WAIT;
        end
      end
      cihs_pkg::S_CD_WAIT:
      begin
        if (!carrier_detect_n)
        begin
          ev[cihs_pkg::EV_CARRIER] = 1'b1;
          next_s.st                = cihs_pkg::S_FSK_RX;
        end
        else if (tmr.expired)
        begin
          ev[cihs_pkg::EV_TIMEOUT] = 1'b1;
          next_s.wake              = 1'b0;
          next_s.load              = 1'b0;
          next_s.st                = cihs_pkg::S_IDLE;
        end
      end
      cihs_pkg::S_FSK_RX:
      begin
        if (carrier_detect_n && s.load)
        begin
          next_s.tmr_start = 1'b1;
          next_s.tmr_ms    = cihs_pkg::LOAD_OFF_MS;
          next_s.st        = cihs_pkg::S_POST_FSK;
        end
        else if (carrier_detect_n)
        begin
          ev[cihs_pkg::EV_DONE] = 1'b1;
          next_s.wake           = 1'b0;
          next_s.skip_ring      = 1'b1;
          next_s.st             = cihs_pkg::S_IDLE;
        end
      end
      cihs_pkg::S_POST_FSK:
      begin
        if (tmr.expired)
        begin
          ev[cihs_pkg::EV_DONE] = 1'b1;
          next_s.load           = 1'b0;
          next_s.wake           = 1'b0;
          next_s.skip_ring      = 1'b1;
          next_s.st             = cihs_pkg::S_IDLE;
        end
      end
      cihs_pkg::S_OH_ALERT:
      begin
        ev[cihs_pkg::EV_ALERT] = alert_fall;
        if (wr_acc && avs_address == cihs_pkg::ADDR_CTRL && avs_writedata[cihs_pkg::CTRL_ACK_DONE])
        begin
          next_s.sel       = 1'b1;
          next_s.tmr_start = 1'b1;
          next_s.tmr_ms    = s.fsk_to;
          next_s.st        = cihs_pkg::S_OH_FSK_WAIT;
        end
      end
      cihs_pkg::S_OH_FSK_WAIT:
      begin
        if (!carrier_detect_n)
        begin
          ev[cihs_pkg::EV_CARRIER] = 1'b1;
          next_s.st                = cihs_pkg::S_OH_FSK;
        end
        else if (tmr.expired)
        begin
          ev[cihs_pkg::EV_TIMEOUT] = 1'b1;
          next_s.sel               = 1'b0;
          next_s.mute              = 1'b0;
          next_s.keypad            = 1'b1;
          next_s.wake              = 1'b0;
          next_s.st                = cihs_pkg::S_IDLE;
        end
      end
      cihs_pkg::S_OH_FSK:
      begin
        if (carrier_detect_n)
        begin
          ev[cihs_pkg::EV_DONE] = 1'b1;
          next_s.sel            = 1'b0;
          next_s.mute           = 1'b0;
          next_s.keypad         = 1'b1;
          next_s.wake           = 1'b0;
          next_s.st             = cihs_pkg::S_IDLE;
        end
      end
      default:
      begin
        next_s.st = cihs_pkg::S_IDLE;
      end
    endcase
    // A new event wins over a clear written in the same cycle.
    if (wr_acc && avs_address == cihs_pkg::ADDR_CTRL)
    begin
      next_s.mode      = avs_writedata[cihs_pkg::CTRL_MODE_LSB +: 2];
      next_s.wake_late = avs_writedata[cihs_pkg::CTRL_WAKE_LATE];
      next_s.sel_high  = avs_writedata[cihs_pkg::CTRL_SEL_HIGH];
      next_s.enable    = avs_writedata[cihs_pkg::CTRL_ENABLE];
    end
    else if (wr_acc && avs_address == cihs_pkg::ADDR_IRQ_STAT)
    begin
      next_s.irq_stat = s.irq_stat & ~avs_writedata[4:0];
    end
    else if (wr_acc && avs_address == cihs_pkg::ADDR_IRQ_MASK)
    begin
      next_s.irq_mask = avs_writedata[4:0];
    end
    else if (wr_acc && avs_address == cihs_pkg::ADDR_CD_TO)
    begin
      next_s.cd_to = avs_writedata[15:0];
    end
    else if (wr_acc && avs_address == cihs_pkg::ADDR_FSK_TO)
    begin
      next_s.fsk_to = avs_writedata[15:0];
    end
    next_s.irq_stat = next_s.irq_stat | ev;
    next_s.irq      = |(next_s.irq_stat & next_s.irq_mask);
    if (rd_take)
    begin
      if (avs_address == cihs_pkg::ADDR_CTRL)
      begin
        next_s.rdata = {27'h0000000, s.enable, s.sel_high, s.wake_late, s.mode};
      end
      else if (avs_address == cihs_pkg::ADDR_STATUS)
      begin
        next_s.rdata = {23'h000000, s.skip_ring, !carrier_detect_n, s.load, s.sel, s.wake, s.st};
      end
      else if (avs_address == cihs_pkg::ADDR_IRQ_STAT)
      begin
        next_s.rdata = {27'h0000000, s.irq_stat};
      end
      else if (avs_address == cihs_pkg::ADDR_IRQ_MASK)
      begin
        next_s.rdata = {27'h0000000, s.irq_mask};
      end
      else if (avs_address == cihs_pkg::ADDR_CD_TO)
      begin
        next_s.rdata = {16'h0000, s.cd_to};
      end
      else if (avs_address == cihs_pkg::ADDR_FSK_TO)
      begin
        next_s.rdata = {16'h0000, s.fsk_to};
      end
      else
      begin
        next_s.rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      s         <= '0;
      s.st      <= cihs_pkg::S_IDLE;
      s.keypad  <= 1'b1;
      s.waitreq <= 1'b1;
      s.cd_to   <= cihs_pkg::CD_TO_RESET;
      s.fsk_to  <= cihs_pkg::FSK_TO_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  AST_SEL_LOW_ALERT: assert property ((s.st == cihs_pkg::S_ALERT || s.st == cihs_pkg::S_OH_ALERT) |-> !detector_select)
    else $error("Detector select high while alert tone expected.");
  AST_SEL_HIGH_ACK: assert property ((s.st == cihs_pkg::S_OH_ALERT && wr_acc && avs_address == cihs_pkg::ADDR_CTRL
    && avs_writedata[cihs_pkg::CTRL_ACK_DONE]) |=> detector_select && s.st == cihs_pkg::S_OH_FSK_WAIT)
    else $error("Select not raised after acknowledge.");
  AST_SEL_LOW_CD_END: assert property ((s.st == cihs_pkg::S_OH_FSK && carrier_detect_n)
    |=> !detector_select && !rx_wake && !handset_mute && keypad_enable)
    else $error("Select not lowered after off-hook carrier end.");
  AST_SLEEP_CD_END: assert property ((s.st == cihs_pkg::S_FSK_RX && carrier_detect_n && !line_load)
    |=> !rx_wake && s.skip_ring)
    else $error("Receiver not put to sleep after carrier end.");
  AST_CD_TIMEOUT: assert property ((s.st == cihs_pkg::S_CD_WAIT && carrier_detect_n && tmr.expired)
    |=> !rx_wake && !line_load && s.irq_stat[cihs_pkg::EV_TIMEOUT])
    else $error("Carrier timeout did not sleep the receiver.");
  AST_OH_FAIL: assert property ((s.st == cihs_pkg::S_OH_FSK_WAIT && carrier_detect_n && tmr.expired)
    |=> !detector_select && !handset_mute && keypad_enable && s.st == cihs_pkg::S_IDLE)
    else $error("Failed off-hook attempt not recovered.");
  AST_LOAD_DELAY: assert property ($rose(line_load) |-> $past(s.st) == cihs_pkg::S_LOAD_DLY
    && $past(tmr.expired))
    else $error("Line load applied outside its delay.");
  AST_ALERT_DELAY: assert property ((s.st == cihs_pkg::S_ALERT && alert_fall)
    |=> tmr.start && tmr.ms == cihs_pkg::LOAD_ALERT_MS ##1 !line_load)
    else $error("Alert end did not start the load delay.");
  AST_LOAD_OFF: assert property ((s.st == cihs_pkg::S_POST_FSK && tmr.expired) |=> !line_load && !rx_wake)
    else $error("Line load not removed after FSK end.");
  AST_SKIP_RING: assert property ((s.st == cihs_pkg::S_IDLE && s.enable && s.skip_ring && ring_rise && !wr_acc)
    |=> s.st == cihs_pkg::S_IDLE && !rx_wake && !s.skip_ring)
    else $error("Receiver woken at skipped ring.");

endmodule : cihs_sequencer

// *** verification/cihs_rx_model.sv ***
// Pin-level behavioural model of the caller-ID receiver.
module cihs_rx_model #(
  parameter int DET_CYC = 50
) (
  input  wire logic core_clk,
  input  wire logic rx_wake,
  input  wire logic detector_select,
  input  wire logic ring_line,
  input  wire logic tone_line,
  input  wire logic fsk_line,
  output logic      ring_on_indication,
  output logic      alert_detect,
  output logic      carrier_detect_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int  cnt = 0;
  logic fsk_ok;
  // ---------------------------------------------------------------------------
  // Detectors
  // ---------------------------------------------------------------------------
  // A high ring line is taken as ringing.
  assign ring_on_indication = ring_line;
  // Tones are heard only while awake with the alert detector selected.
  assign alert_detect = tone_line & rx_wake & ~detector_select;
  assign fsk_ok = fsk_line & rx_wake & detector_select;
  // The carrier flag waits for the demodulator to settle, so a host that looks too early sees nothing.
  always @(posedge core_clk)
    cnt <= !fsk_ok ? 0 : (cnt < DET_CYC) ? cnt + 1 : cnt;
  assign carrier_detect_n = !(cnt >= DET_CYC);
endmodule : cihs_rx_model

// *** verification/caller_id_host_sequencer_bench.sv ***
// Self-checking bench of the caller-ID host sequencer.
module caller_id_host_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 10;
  logic        core_clk      = 1'b0;
  logic        nrst          = 1'b0;
  logic [7:0]  avs_address   = 8'h00;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic        ring_line     = 1'b0;
  logic        tone_line     = 1'b0;
  logic        fsk_line      = 1'b0;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, ring_on_indication, alert_detect, carrier_detect_n;
  logic        rx_wake, detector_select, line_load, handset_mute, keypad_enable, irq;
  int          miscompares   = 0;
  int          n_compared    = 0;
  int          cycles        = 0;
  int          n;

  cihs_sequencer #(.MS_DIV(MS)) dut_u (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ring_on_indication(ring_on_indication), .alert_detect(alert_detect),
    .carrier_detect_n(carrier_detect_n), .rx_wake(rx_wake), .detector_select(detector_select),
    .line_load(line_load), .handset_mute(handset_mute), .keypad_enable(keypad_enable), .irq(irq));
  cihs_rx_model rx_u (.core_clk(core_clk), .rx_wake(rx_wake), .detector_select(detector_select),
    .ring_line(ring_line), .tone_line(tone_line), .fsk_line(fsk_line), .ring_on_indication(ring_on_indication),
    .alert_detect(alert_detect), .carrier_detect_n(carrier_detect_n));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  initial forever #5 core_clk = ~core_clk;

  task automatic report_and_stop;
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // The ceiling is several times the longest sequence, so only a hang reaches it.
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  function automatic logic pin(input int i);
    case (i)
      0: return rx_wake;
      1: return detector_select;
      2: return line_load;
      default: return carrier_detect_n;
    endcase
  endfunction : pin

  task automatic wait_pin(input int i, input logic v);
    n = 0;
    while (pin(i) !== v)
    begin
      @(posedge core_clk);
      n++;
    end
  endtask : wait_pin

  task automatic step(input logic r, input logic t, input logic f);
    @(posedge core_clk);
    ring_line <= r;
    tone_line <= t;
    fsk_line <= f;
    repeat (3) @(posedge core_clk);
  endtask : step

  task automatic fsk_burst(input int i);
    step(1'b0, 1'b0, 1'b1);
    wait_pin(3, 1'b0);
    step(1'b0, 1'b0, 1'b0);
    wait_pin(i, 1'b0);
  endtask : fsk_burst

  task automatic skip_ring;
    step(1'b1, 1'b0, 1'b0);
    check("skip_wake", rx_wake, 1'b0);
    step(1'b0, 1'b0, 1'b0);
  endtask : skip_ring

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    check("rst_pins", {rx_wake, detector_select, line_load, handset_mute, keypad_enable, irq}, 6'h02);
    bus(1'b0, cihs_pkg::ADDR_CD_TO, 32'h0);
    check("cd_to", rd, 32'h00000bb8);
    bus(1'b0, cihs_pkg::ADDR_FSK_TO, 32'h0);
    check("fsk_to", rd, 32'h000001f4);
    bus(1'b1, 8'h20, 32'h0000ffff);
    bus(1'b0, 8'h20, 32'h0);
    check("unmapped", rd, 32'h00000000);
    bus(1'b1, cihs_pkg::ADDR_CD_TO, 32'h00000028);
    bus(1'b1, cihs_pkg::ADDR_FSK_TO, 32'h0000001e);
    bus(1'b1, cihs_pkg::ADDR_IRQ_MASK, 32'h0000001f);
  endtask : t_reset

  task automatic t_ring;
    bus(1'b1, cihs_pkg::ADDR_CTRL, 32'h00000018);
    bus(1'b0, cihs_pkg::ADDR_CTRL, 32'h0);
    check("ctrl_rd", rd, 32'h00000018);
    check("idle_sel", detector_select, 1'b1);
    step(1'b1, 1'b0, 1'b0);
    check("ring_wake", rx_wake, 1'b1);
    step(1'b0, 1'b0, 1'b0);
    fsk_burst(0);
    check("sleep_delay", n <= 4, 1'b1);
    bus(1'b0, cihs_pkg::ADDR_IRQ_STAT, 32'h0);
    check("done_flag", rd[2], 1'b1);
    check("irq_set", irq, 1'b1);
    bus(1'b1, cihs_pkg::ADDR_IRQ_STAT, 32'h0000001f);
    repeat (3) @(posedge core_clk);
    check("irq_clr", irq, 1'b0);
    skip_ring();
  endtask : t_ring

  task automatic t_timeout;
    bus(1'b1, cihs_pkg::ADDR_IRQ_MASK, 32'h00000008);
    step(1'b1, 1'b0, 1'b0);
    check("to_wake", rx_wake, 1'b1);
    check("irq_masked", irq, 1'b0);
    step(1'b0, 1'b0, 1'b0);
    wait_pin(0, 1'b0);
    check("to_delay", n > 36 * MS && n < 41 * MS, 1'b1);
    bus(1'b0, cihs_pkg::ADDR_IRQ_STAT, 32'h0);
    check("to_flag", rd[3], 1'b1);
    check("to_irq", irq, 1'b1);
    bus(1'b1, cihs_pkg::ADDR_IRQ_STAT, 32'h0000001f);
    bus(1'b1, cihs_pkg::ADDR_IRQ_MASK, 32'h0000001f);
  endtask : t_timeout

  task automatic t_late;
    bus(1'b1, cihs_pkg::ADDR_CTRL, 32'h00000014);
    step(1'b1, 1'b0, 1'b0);
    check("late_ring", rx_wake, 1'b0);
    step(1'b0, 1'b0, 1'b0);
    check("late_wake", rx_wake, 1'b1);
    fsk_burst(0);
    skip_ring();
  endtask : t_late

  task automatic t_alert;
    bus(1'b1, cihs_pkg::ADDR_CTRL, 32'h00000019);
    repeat (2) @(posedge core_clk);
    check("al_idle_sel", detector_select, 1'b0);
    step(1'b1, 1'b0, 1'b0);
    check("al_sel", {rx_wake, detector_select}, 2'h2);
    step(1'b0, 1'b1, 1'b0);
    step(1'b0, 1'b0, 1'b0);
    wait_pin(2, 1'b1);
    check("al_load", n + 4 >= 15 * MS && n + 4 <= 25 * MS, 1'b1);
    check("al_fsk", detector_select, 1'b1);
    fsk_burst(2);
    check("al_unload", n + 4 >= 50 * MS && n <= 150 * MS, 1'b1);
    check("al_sleep", rx_wake, 1'b0);
    skip_ring();
  endtask : t_alert

  task automatic t_burst;
    bus(1'b1, cihs_pkg::ADDR_CTRL, 32'h00000012);
    step(1'b1, 1'b0, 1'b0);
    step(1'b0, 1'b0, 1'b0);
    wait_pin(2, 1'b1);
    check("bu_load", n + 4 >= 250 * MS && n <= 400 * MS, 1'b1);
    fsk_burst(2);
    check("bu_unload", n + 4 >= 50 * MS && n <= 150 * MS, 1'b1);
    skip_ring();
  endtask : t_burst

  task automatic t_offhook(input logic fsk);
    bus(1'b1, cihs_pkg::ADDR_CTRL, 32'h00000110);
    repeat (3) @(posedge core_clk);
    check("oh_start", {rx_wake, detector_select, handset_mute, keypad_enable}, 4'ha);
    bus(1'b0, cihs_pkg::ADDR_STATUS, 32'h0);
    check("oh_status", rd, 32'h00000017);
    bus(1'b1, cihs_pkg::ADDR_CTRL, 32'h00000210);
    repeat (3) @(posedge core_clk);
    check("oh_ack", detector_select, 1'b1);
    if (fsk)
    begin
      fsk_burst(1);
      check("oh_sel_off", n <= 4, 1'b1);
    end
    else
    begin
      wait_pin(1, 1'b0);
      check("oh_wait", n > 26 * MS && n < 31 * MS, 1'b1);
      bus(1'b0, cihs_pkg::ADDR_IRQ_STAT, 32'h0);
      check("oh_to_flag", rd[3], 1'b1);
    end
    repeat (2) @(posedge core_clk);
    check("oh_restore", {detector_select, handset_mute, keypad_enable}, 3'h1);
    bus(1'b1, cihs_pkg::ADDR_IRQ_STAT, 32'h0000001f);
  endtask : t_offhook

  initial
  begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_ring();
    t_timeout();
    t_late();
    t_alert();
    t_burst();
    t_offhook(1'b1);
    t_offhook(1'b0);
    report_and_stop();
  end
endmodule : caller_id_host_sequencer_bench
